// *** logic/dtr_pkg.sv ***
package dtr_pkg;
  // Operating mode codes
  localparam logic [1:0] MODE_PRIME    = 2'h1;
  localparam logic [1:0] MODE_DISPENSE = 2'h2;
  localparam logic [1:0] MODE_METER    = 2'h3;
  // Ready configuration mask bits
  localparam int         CFG_SYS_PRIME  = 1;
  localparam int         CFG_SYS_FAULT  = 3;
  localparam int         CFG_CH_PRIME   = 5;
  localparam int         CFG_CH_FAULT   = 7;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  // Fault codes
  localparam logic [11:0] CODE_NONE     = 12'h000;
  localparam logic [11:0] CODE_OTHER_CH = 12'd1000;
  localparam logic [11:0] CODE_ROTARY   = 12'd1002;
  localparam logic [7:0]  STALL_LIMIT_DEF = 8'h04;
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_FAULT} dtr_state_t;
endpackage

// *** logic/dtr_core.sv ***
module dtr_core
  import dtr_pkg::*;
#(
  parameter int NCH = 4
) (
  input  wire logic             REF_CLK,        // 100 MHz clock
  input  wire logic             NRST,           // Sync reset, active low
  input  wire logic             SYS_TRIG_IN,    // System trigger contact, closed is true
  input  wire logic [NCH-1:0]   CH_TRIG_IN,     // Channel trigger contacts
  input  wire logic [NCH*2-1:0] CH_MODE,        // Mode per channel
  input  wire logic [7:0]       READY_CFG,      // Ready configuration mask
  input  wire logic [NCH-1:0]   REF_REQ,        // Channel needs reference
  input  wire logic [NCH-1:0]   OP_DONE,        // Channel operation finished pulse
  input  wire logic [NCH-1:0]   STALL,          // Channel motor stall pulse
  input  wire logic [7:0]       STALL_LIMIT,    // Stalls before fault
  input  wire logic             FAULT_CLR,      // Clear all faults pulse
  output logic [NCH-1:0]        CH_START,       // Channel start pulse
  output logic                  SYS_READY_OUT,  // System ready switch
  output logic [NCH-1:0]        CH_READY_OUT,   // Channel ready switches
  output logic                  FAULT_OUT,      // Inverted fault switch
  output logic [NCH*12-1:0]     FAULT_CODE      // Fault code per channel
);

  logic [NCH:0]      s1_reg;
  logic [NCH:0]      s2_reg;
  logic [NCH:0]      s3_reg;
  logic [NCH:0]      rise;
  logic [NCH-1:0]    faulted_reg;
  logic [NCH-1:0]    busy_reg;
  logic              any_fault;
  logic [NCH-1:0]    go;
  logic [11:0]       code_reg [NCH];
  logic              sys_ready;
  dtr_state_t        state_reg;

  function automatic logic [1:0] mode_of(input logic [NCH*2-1:0] m, input int i);
    mode_of = m[i*2 +: 2];
  endfunction

  // Contact closure drives the pin high; synchroniser then edge detect
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= {SYS_TRIG_IN, CH_TRIG_IN};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign rise = s2_reg & ~s3_reg;
  assign any_fault = |faulted_reg;

  // System level: a sys trigger in ST_IDLE drives every unblocked channel in Dispense or Prime mode
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE:  if (any_fault) state_reg <= ST_FAULT;
                  else if (rise[NCH] || |go) state_reg <= ST_BUSY;
        ST_BUSY:  if (any_fault) state_reg <= ST_FAULT;
                  else if (busy_reg == '0) state_reg <= ST_IDLE;
        ST_FAULT: if (!any_fault) state_reg <= ST_IDLE;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gch
      logic [1:0] md;
      logic [7:0] stall_cnt_reg;
      logic       ch_block;
      logic       ch_ready;
      logic       own_mode;
      logic       sys_mode;
      assign md = mode_of(CH_MODE, g);
      assign own_mode = (md == MODE_DISPENSE) || (md == MODE_METER);
      assign sys_mode = (md == MODE_DISPENSE) || (md == MODE_PRIME);
      assign ch_block = faulted_reg[g] | REF_REQ[g] | busy_reg[g];
      // Own trigger: Dispense or Meter only; system trigger: Dispense or Prime
      assign go[g] = !ch_block && !any_fault &&
                     ((rise[g] && own_mode) ||
                      (rise[NCH] && state_reg == ST_IDLE && sys_mode));
      always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
          busy_reg[g]    <= 1'b0;
          faulted_reg[g] <= 1'b0;
          stall_cnt_reg  <= 8'h00;
          code_reg[g]    <= CODE_NONE;
          CH_START[g]    <= 1'b0;
        end else begin
          CH_START[g] <= go[g];
          if (go[g]) begin
            busy_reg[g]   <= 1'b1;
            stall_cnt_reg <= 8'h00;
          end else if (OP_DONE[g] || faulted_reg[g]) begin
            busy_reg[g] <= 1'b0;
          end
          if (busy_reg[g] && STALL[g] && !faulted_reg[g]) begin
            stall_cnt_reg <= stall_cnt_reg + 8'h01;
            if (stall_cnt_reg + 8'h01 >= STALL_LIMIT) begin
              faulted_reg[g] <= 1'b1;
              code_reg[g]    <= CODE_ROTARY;
            end
          end else if (FAULT_CLR) begin
            faulted_reg[g] <= 1'b0;
            code_reg[g]    <= CODE_NONE;
          end else if (!faulted_reg[g] && any_fault) begin
            code_reg[g] <= CODE_OTHER_CH;
          end else if (!any_fault) begin
            code_reg[g] <= CODE_NONE;
          end
        end
      end
      assign ch_ready = !busy_reg[g] &&
                        !(READY_CFG[CFG_CH_PRIME] && md == MODE_PRIME) &&
                        !(READY_CFG[CFG_CH_FAULT] && (faulted_reg[g] || REF_REQ[g]));
      always_ff @(posedge REF_CLK) begin
        if (!NRST) CH_READY_OUT[g] <= 1'b0;
        else CH_READY_OUT[g] <= ch_ready;
      end
      assign FAULT_CODE[g*12 +: 12] = code_reg[g];

      // Per-channel checks
      ch_retrig_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        CH_START[g] |=> !CH_START[g])
        else $error("start pulse longer than one cycle");

      ch_done_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (busy_reg[g] && OP_DONE[g]) |=> !busy_reg[g])
        else $error("channel stayed busy after done");

      ch_block_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        ch_block |-> !go[g])
        else $error("blocked channel accepted trigger");

      ch_prime_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (rise[g] && !rise[NCH] && md == MODE_PRIME) |-> !go[g])
        else $error("own trigger started prime channel");

      ch_meter_sys_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (rise[NCH] && !rise[g] && md == MODE_METER) |-> !go[g])
        else $error("system trigger started meter channel");

      ch_own_go_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (rise[g] && !ch_block && !any_fault && md == MODE_METER) |-> go[g])
        else $error("own trigger not accepted in meter");

      ch_sys_go_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (rise[NCH] && state_reg == ST_IDLE && !ch_block && !any_fault && md == MODE_PRIME) |-> go[g])
        else $error("system trigger not accepted in prime");

      ch_start_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        go[g] |=> CH_START[g])
        else $error("accepted trigger gave no start");

      ch_sync_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        rise[g] |-> $past(CH_TRIG_IN[g], 2))
        else $error("channel edge seen before two stages");

      stall_clear_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        go[g] |=> (stall_cnt_reg == 8'h00))
        else $error("stall count not cleared at start");

      stall_fault_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (busy_reg[g] && STALL[g] && !faulted_reg[g] && (stall_cnt_reg + 8'h01 >= STALL_LIMIT)) |=> faulted_reg[g])
        else $error("stall limit reached without fault");

      fault_cause_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        $rose(faulted_reg[g]) |-> $past(STALL[g]))
        else $error("fault without stall");

      other_code_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (!faulted_reg[g] && any_fault && !FAULT_CLR && !(busy_reg[g] && STALL[g]))
        |=> (code_reg[g] == CODE_OTHER_CH))
        else $error("other channel code missing");

      code_legal_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (code_reg[g] == CODE_NONE) || (code_reg[g] == CODE_OTHER_CH) || (code_reg[g] == CODE_ROTARY))
        else $error("reserved fault code issued");

      clear_fault_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (FAULT_CLR && !(busy_reg[g] && STALL[g])) |=> (!faulted_reg[g] && code_reg[g] == CODE_NONE))
        else $error("fault clear ignored");

      ch_busy_rdy_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        busy_reg[g] |=> !CH_READY_OUT[g])
        else $error("channel ready while busy");

      ch_idle_rdy_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (!busy_reg[g] && !faulted_reg[g] && !REF_REQ[g] && md != MODE_PRIME) |=> CH_READY_OUT[g])
        else $error("idle channel not ready");

      ch_prime_mask_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (READY_CFG[CFG_CH_PRIME] && md == MODE_PRIME) |=> !CH_READY_OUT[g])
        else $error("prime mask ignored on channel ready");

      ch_ref_mask_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (READY_CFG[CFG_CH_FAULT] && (faulted_reg[g] || REF_REQ[g])) |=> !CH_READY_OUT[g])
        else $error("fault mask ignored on channel ready");
    end
  endgenerate

  assign sys_ready = state_reg == ST_IDLE && !any_fault &&
                     !(READY_CFG[CFG_SYS_PRIME] && mode_of(CH_MODE, 0) == MODE_PRIME) &&
                     !(READY_CFG[CFG_SYS_FAULT] && |REF_REQ);

  // Outputs high mean switch conducts
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      SYS_READY_OUT <= 1'b0;
      FAULT_OUT     <= 1'b1;
    end else begin
      SYS_READY_OUT <= sys_ready && !rise[NCH] && (go == '0);
      FAULT_OUT     <= !any_fault;
    end
  end

  ready_not_busy_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (state_reg == ST_BUSY) |=> !SYS_READY_OUT)
    else $error("ready asserted while busy");
  fault_inverted_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    any_fault |=> !FAULT_OUT)
    else $error("fault output not low while faulted");
  sync_start_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (|CH_START) |-> $past(|go))
    else $error("start without detected edge");
  prime_no_ch_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (rise[0] && !rise[NCH] && mode_of(CH_MODE, 0) == MODE_PRIME) |-> !go[0])
    else $error("channel trigger started in prime");
  ignore_busy_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    busy_reg[0] |-> !go[0])
    else $error("retrigger during operation");
  ref_block_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (REF_REQ[0] || faulted_reg[0]) |-> !go[0])
    else $error("trigger accepted while blocked");
  fault_start_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    any_fault |-> (go == '0))
    else $error("start while faulted");
  rotary_code_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $rose(faulted_reg[0]) |-> code_reg[0] == CODE_ROTARY)
    else $error("wrong fault code");

  // System-level checks
  sys_fault_rdy_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    any_fault |=> !SYS_READY_OUT)
    else $error("system ready while faulted");

  sys_idle_rdy_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (state_reg == ST_IDLE && !any_fault && !rise[NCH] && go == '0 &&
     !READY_CFG[CFG_SYS_PRIME] && !READY_CFG[CFG_SYS_FAULT]) |=> SYS_READY_OUT)
    else $error("idle system not ready");

  sys_prime_mask_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (READY_CFG[CFG_SYS_PRIME] && mode_of(CH_MODE, 0) == MODE_PRIME) |=> !SYS_READY_OUT)
    else $error("prime mask ignored on system ready");

  sys_ref_mask_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (READY_CFG[CFG_SYS_FAULT] && |REF_REQ) |=> !SYS_READY_OUT)
    else $error("reference mask ignored on system ready");

  no_fault_out_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !any_fault |=> FAULT_OUT)
    else $error("fault output low without fault");

  fault_state_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    any_fault |=> (state_reg == ST_FAULT))
    else $error("fault state not entered");

  fault_idle_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (state_reg == ST_FAULT && !any_fault) |=> (state_reg == ST_IDLE))
    else $error("fault state not left after clear");

  busy_exit_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (state_reg == ST_BUSY && busy_reg == '0 && !any_fault) |=> (state_reg == ST_IDLE))
    else $error("system stuck busy");

  sys_go_busy_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (state_reg == ST_IDLE && !any_fault && (rise[NCH] || |go)) |=> (state_reg == ST_BUSY))
    else $error("start did not make system busy");

  sync_depth_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    rise[NCH] |-> $past(SYS_TRIG_IN, 2))
    else $error("system edge seen before two stages");

endmodule

// *** sim/dtr_plc.sv ***
module dtr_plc #(
  parameter int DLY = 40
) (
  input  wire logic       clk,   // Device clock
  input  wire logic [3:0] start, // Start pulses from the controller
  output logic      [3:0] done   // Completion pulses, DLY cycles later
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] run_reg [DLY];
  initial run_reg = '{default: 4'h0};
  always @(posedge clk) begin
    run_reg[0] <= start;
    for (int i = 1; i < DLY; i++) run_reg[i] <= run_reg[i-1];
  end
  assign done = run_reg[DLY-1];
endmodule

// *** sim/tb_top.sv ***
module tb_top
  import dtr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, nrst = 0, strig = 0, fclr = 0, clr = 0, srdy, fout;
  logic [3:0]  ctrig = '0, rreq = '0, stall = '0, done, start, crdy, seen;
  logic [7:0]  mode = 8'hAA, cfg = 8'h00, slim = 8'h04;
  logic [47:0] code;
  int          bad_count = 0, n_checks = 0, cyc = 0;
  dtr_core #(.NCH(4)) dut_u (.REF_CLK(clk), .NRST(nrst), .SYS_TRIG_IN(strig), .CH_TRIG_IN(ctrig),
    .CH_MODE(mode), .READY_CFG(cfg), .REF_REQ(rreq), .OP_DONE(done), .STALL(stall), .STALL_LIMIT(slim),
    .FAULT_CLR(fclr), .CH_START(start), .SYS_READY_OUT(srdy), .CH_READY_OUT(crdy), .FAULT_OUT(fout),
    .FAULT_CODE(code));
  dtr_plc #(.DLY(40)) plc_u (.clk(clk), .start(start), .done(done));
  always #5 clk = ~clk;
  always @(posedge clk) seen <= clr ? 4'h0 : seen | start;
  // Hang guard; every scenario together needs well under this
  always @(posedge clk) if (++cyc > 5000) begin
    bad_count++;
    complete_run();
  end
  task automatic complete_run;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] s);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %0h got %0h", nm, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Registered outputs are read mid-cycle, well clear of the launching edge
  task automatic look;
    @(negedge clk);
  endtask
  // Closure held 4 cycles, then starts collected over 8
  task automatic trig(input logic s, input logic [3:0] m);
    tick(1);
    clr <= 1;
    tick(1);
    clr <= 0;
    strig <= s;
    ctrig <= m;
    tick(4);
    strig <= 0;
    ctrig <= 4'h0;
    tick(4);
    look();
  endtask
  task automatic t_busy;
    trig(0, 4'h1); chk("start ch0", 48'h1, seen);
    chk("sys ready busy", 48'h0, srdy);
    chk("ch ready busy", 48'hE, crdy);
    trig(0, 4'h1); chk("retrig busy", 48'h0, seen);
    tick(40);
    look();
    chk("ch ready idle", 48'hF, crdy);
  endtask
  task automatic t_sys;
    trig(1, 4'h0); chk("sys start", 48'hF, seen);
    tick(40);
  endtask
  task automatic t_refuse;
    tick(1);
    mode <= 8'hA6;
    rreq <= 4'h4;
    trig(0, 4'h6);
    chk("prime/ref refused", 48'h0, seen);
    tick(1);
    cfg <= 8'h02;
    mode <= 8'hA9;
    tick(3);
    look();
    chk("cfg prime sys ready", 48'h0, srdy);
    tick(1);
    cfg <= 8'h00;
    tick(3);
    look();
    chk("cfg off sys ready", 48'h1, srdy);
    tick(1);
    rreq <= 4'h0;
    mode <= 8'hEA;
  endtask
  // Reference mask on both kinds of ready, prime mask on channel ready
  task automatic t_cfg;
    tick(1);
    rreq <= 4'h1;
    mode <= 8'hE6;
    cfg <= 8'hA8;
    tick(3);
    look();
    chk("cfg ref sys ready", 48'h0, srdy);
    chk("cfg masks ch ready", 48'hC, crdy);
    tick(1);
    rreq <= 4'h0;
    mode <= 8'hEA;
    cfg <= 8'h00;
    tick(3);
    look();
    chk("ch ready restored", 48'hF, crdy);
    chk("sys ready restored", 48'h1, srdy);
  endtask
  task automatic t_fault;
    trig(0, 4'h8);
    chk("meter start", 48'h8, seen);
    for (int i = 0; i < 4; i++) begin
      tick(1);
      stall <= 4'h8;
      tick(1);
      stall <= 4'h0;
      tick(2);
      look();
      chk("fault out", 48'(i < 3), fout);
    end
    chk("codes", {CODE_ROTARY, CODE_OTHER_CH, CODE_OTHER_CH, CODE_OTHER_CH}, code);
    chk("sys ready fault", 48'h0, srdy);
    tick(40);
    trig(0, 4'h1);
    chk("faulted refused", 48'h0, seen);
    tick(1);
    fclr <= 1;
    tick(1);
    fclr <= 0;
    tick(3);
    look();
    chk("fault cleared", 48'h1, fout);
    chk("codes cleared", 48'h0, code);
  endtask
  initial begin
    tick(20);
    nrst <= 1;
    tick(3);
    look();
    chk("reset fault out", 48'h1, fout);
    chk("reset codes", 48'h0, code);
    t_busy();
    t_sys();
    t_refuse();
    t_cfg();
    t_fault();
    complete_run();
  end
endmodule
